/* rtl/floppy_flow_defs.vh */
// Register map, field positions, command table and reset values of the floppy phase and FIFO flow block.
`ifndef FLOPPY_FLOW_DEFS_VH
`define FLOPPY_FLOW_DEFS_VH
`define REG_STATUS 8'h00
`define REG_DATA 8'h04
`define REG_CTRL 8'h08
`define REG_LEVEL 8'h0C
`define ST_RQM 7
`define ST_DIO 6
`define ST_NDMA 5
`define ST_CB 4
`define CTRL_SRST 0
`define LVL_THR_LSB 8
`define LVL_FIFO_EN 12
`define LVL_DMA 13
`define OP_SPECIFY 5'h03
`define OP_SENSE 5'h08
`define OP_CONFIGURE 5'h13
`define OP_READ 5'h06
`define OP_WRITE 5'h05
`define LEN_SPECIFY 4'h3
`define LEN_SENSE 4'h1
`define LEN_CONFIGURE 4'h4
`define LEN_RW 4'h9
`define RES_SENSE 3'h2
`define RES_RW 3'h7
`define SPEC_NDMA_BIT 0
`define CFG_NOFIFO_BIT 5
`define IX_C 2
`define IX_H 3
`define IX_R 4
`define IX_N 5
`define IX_EOT 6
`define IX_CFG 2
`define FIFO_DEPTH 5'h10
`define SECTOR_LAST 10'h1FF
`define ST0_ABNORMAL 8'h40
`define ST0_INVALID 8'h80
`define RST_DMA 1'b1
`define RST_FIFO_EN 1'b0
`define RST_THR 4'h0
`define SYNC_IDLE 4'h7
`endif

/* rtl/floppy_ctrl_phase_fifo_flow.v */
// Command, execution and result phase sequencing with FIFO flow control of a floppy controller core.
`timescale 1ns/10ps
`include "floppy_flow_defs.vh"

module floppy_ctrl_phase_fifo_flow (
  input wire clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire dma_acknowledge_n_in,
  input wire dma_rd_n_in,
  input wire dma_wr_n_in,
  input wire [7:0] dma_data_in,
  output reg [7:0] dma_data_out,
  input wire terminal_count_input_in,
  output wire dma_request_pin_out,
  output wire fdc_interrupt_pin_out,
  input wire disk_rd_valid_in,
  input wire [7:0] disk_rd_data_in,
  input wire disk_wr_req_in,
  output wire [7:0] disk_wr_data_out,
  output wire disk_wr_valid_out
);
  localparam [3:0] PH_CMD = 4'b0001;
  localparam [3:0] PH_PROC = 4'b0010;
  localparam [3:0] PH_EXEC = 4'b0100;
  localparam [3:0] PH_RES = 4'b1000;

  function [3:0] cmd_len;
    input [7:0] op;
    begin
      case (op[4:0])
        `OP_SPECIFY: cmd_len = `LEN_SPECIFY;
        `OP_SENSE: cmd_len = `LEN_SENSE;
        `OP_CONFIGURE: cmd_len = `LEN_CONFIGURE;
        `OP_READ: cmd_len = `LEN_RW;
        `OP_WRITE: cmd_len = `LEN_RW;
        default: cmd_len = 4'h0;
      endcase
    end
  endfunction

  reg [3:0] s1_q, s2_q, s3_q, pin_q, pin_d1_q;
  reg [3:0] ph_q, nb_q;
  reg [7:0] cmd_q [0:8];
  reg [7:0] res_q [0:6];
  reg [2:0] rn_q, ri_q;
  reg dma_q, fifo_en_q, inv_q, int_q, hreq_q, isrd_q, end_q, abn_q, ddone_q, secend_q;
  reg [3:0] thr_q;
  reg [7:0] sec_q;
  reg [9:0] bc_q;
  reg [17:0] hleft_q;
  reg [7:0] mem [0:15];
  reg [3:0] wp_q, rp_q;
  reg [4:0] cnt_q;
  reg dwv_q;
  reg [7:0] dwd_q;
  reg hreq_d;
  reg [8:0] nsec;
  integer i;

  wire [3:0] agree = ~(s2_q ^ s3_q);
  wire dack_act = ~pin_q[0];
  wire rd_edge = pin_d1_q[1] & ~pin_q[1];
  wire wr_edge = pin_d1_q[2] & ~pin_q[2];
  wire tc_ev = pin_q[3] & ~pin_d1_q[3] & dack_act;
  wire tc_off = ~pin_q[3] & pin_d1_q[3] & ~dack_act;
  wire is_exec = (ph_q == PH_EXEC);
  wire is_res = (ph_q == PH_RES);
  wire is_cmd = (ph_q == PH_CMD);
  wire [4:0] cap = fifo_en_q ? `FIFO_DEPTH : 5'h01;
  wire full = (cnt_q == cap);
  wire empty = (cnt_q == 5'h00);
  wire [4:0] rd_lvl = fifo_en_q ? (5'h0F - {1'b0, thr_q}) : 5'h01;
  wire [4:0] wr_thr = fifo_en_q ? ({1'b0, thr_q} + 5'h01) : 5'h00;
  wire acc = psel_in & penable_in;
  wire mapped = (paddr_in == `REG_STATUS) | (paddr_in == `REG_DATA) |
                (paddr_in == `REG_CTRL) | (paddr_in == `REG_LEVEL);
  wire hw_data = acc & pwrite_in & (paddr_in == `REG_DATA);
  wire hr_data = acc & ~pwrite_in & (paddr_in == `REG_DATA);
  wire srst = acc & pwrite_in & (paddr_in == `REG_CTRL) & pwdata_in[`CTRL_SRST];
  wire cpu_wr = hw_data & is_exec & ~dma_q & ~isrd_q & hreq_q;
  wire dma_wr = wr_edge & dack_act & is_exec & dma_q & ~isrd_q;
  wire host_push = (cpu_wr | dma_wr) & ~full & ~end_q & (hleft_q != 18'h00000);
  wire cpu_rd = hr_data & is_exec & ~dma_q & isrd_q & hreq_q;
  wire dma_rd = rd_edge & dack_act & is_exec & dma_q & isrd_q;
  wire host_pop = (cpu_rd | dma_rd) & ~empty;
  wire disk_try_rd = is_exec & isrd_q & disk_rd_valid_in & ~ddone_q;
  wire disk_push = disk_try_rd & ~full;
  wire overrun = disk_try_rd & full;
  wire disk_wr = is_exec & ~isrd_q & disk_wr_req_in & ~ddone_q;
  wire underrun = disk_wr & empty;
  wire disk_pop = disk_wr & ~empty;
  wire step = disk_push | disk_wr;
  wire end_now = end_q | tc_ev | underrun;
  wire push = host_push | disk_push;
  wire pop = host_pop | disk_pop;
  wire [7:0] push_data = disk_push ? disk_rd_data_in : (dma_wr ? dma_data_in : pwdata_in[7:0]);
  wire last_dma = dack_act & (isrd_q ? (ddone_q & (cnt_q == 5'h01)) : (hleft_q == 18'h00001));
  wire [7:0] status = {(is_cmd | is_res | (is_exec & ~dma_q & hreq_q)),
                       (is_res | (is_exec & isrd_q)), (is_exec & ~dma_q),
                       ~(is_cmd & (nb_q == 4'h0)), 4'h0};

  assign pready_out = 1'b1;
  assign pslverr_out = acc & ~mapped;
  assign dma_request_pin_out = is_exec & dma_q & hreq_q & ~last_dma;
  assign fdc_interrupt_pin_out = int_q;
  assign disk_wr_data_out = dwd_q;
  assign disk_wr_valid_out = dwv_q;

  // Pins settle through three flops; a level counts only once the last two agree.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= `SYNC_IDLE;
      s2_q <= `SYNC_IDLE;
      s3_q <= `SYNC_IDLE;
      pin_q <= `SYNC_IDLE;
      pin_d1_q <= `SYNC_IDLE;
    end else begin
      s1_q <= {terminal_count_input_in, dma_wr_n_in, dma_rd_n_in, dma_acknowledge_n_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (pin_q & ~agree) | (s3_q & agree);
      pin_d1_q <= pin_q;
    end
  end

  // Transfer request flow; the full check comes first so a threshold of 16 still releases.
  always @* begin
    hreq_d = hreq_q;
    if (!is_exec) begin
      hreq_d = 1'b0;
    end else if (isrd_q) begin
      if (empty) begin
        hreq_d = 1'b0;
      end else if ((cnt_q >= rd_lvl) | secend_q) begin
        hreq_d = 1'b1;
      end
    end else begin
      if (end_now | (hleft_q == 18'h00000) | full) begin
        hreq_d = 1'b0;
      end else if (cnt_q <= wr_thr) begin
        hreq_d = 1'b1;
      end
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h00000000;
      dma_data_out <= 8'h00;
    end else begin
      dma_data_out <= mem[rp_q];
      if (psel_in & ~penable_in) begin
        case (paddr_in)
          `REG_STATUS: prdata_out <= {24'h000000, status};
          `REG_DATA: prdata_out <= {24'h000000, is_res ? res_q[ri_q] : mem[rp_q]};
          `REG_LEVEL: prdata_out <= {18'h00000, dma_q, fifo_en_q, thr_q, 3'h0, cnt_q};
          default: prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // FIFO storage is left unreset; pointers and count define what is valid.
  always @(posedge clk_in) begin
    if (push) begin
      mem[wp_q] <= push_data;
    end
    if (ph_q == PH_PROC) begin
      if (cmd_q[0][4:0] == `OP_SENSE) begin
        res_q[0] <= inv_q ? `ST0_INVALID : 8'h00;
        res_q[1] <= 8'h00;
      end
    end
    if (hw_data & is_cmd & (nb_q < 4'h9)) begin
      cmd_q[nb_q] <= pwdata_in[7:0];
    end
    if (is_exec & ddone_q & empty) begin
      res_q[0] <= abn_q ? `ST0_ABNORMAL : 8'h00;
      res_q[1] <= 8'h00;
      res_q[2] <= 8'h00;
      res_q[3] <= cmd_q[`IX_C];
      res_q[4] <= cmd_q[`IX_H];
      res_q[5] <= sec_q;
      res_q[6] <= cmd_q[`IX_N];
    end
  end

  task clear_core;
    begin
      ph_q <= PH_CMD;
      nb_q <= 4'h0;
      rn_q <= 3'h0;
      ri_q <= 3'h0;
      fifo_en_q <= `RST_FIFO_EN;
      thr_q <= `RST_THR;
      inv_q <= 1'b0;
      int_q <= 1'b0;
      hreq_q <= 1'b0;
      isrd_q <= 1'b0;
      end_q <= 1'b0;
      abn_q <= 1'b0;
      ddone_q <= 1'b0;
      secend_q <= 1'b0;
      sec_q <= 8'h00;
      bc_q <= 10'h000;
      hleft_q <= 18'h00000;
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
      dwv_q <= 1'b0;
      dwd_q <= 8'h00;
    end
  endtask

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clear_core;
      dma_q <= `RST_DMA;
    end else if (srst) begin
      clear_core;
    end else begin
      hreq_q <= hreq_d;
      dwv_q <= disk_wr;
      if (push) begin
        wp_q <= (wp_q + 4'h1) & (cap[4] ? 4'hF : 4'h0);
      end
      if (pop) begin
        rp_q <= (rp_q + 4'h1) & (cap[4] ? 4'hF : 4'h0);
      end
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
      if (disk_wr) begin
        dwd_q <= empty ? 8'h00 : mem[rp_q];
      end
      if (host_push) begin
        hleft_q <= hleft_q - 18'h00001;
      end
      case (ph_q)
        PH_CMD: begin
          if (hw_data) begin
            nb_q <= nb_q + 4'h1;
            ph_q <= PH_PROC;
          end
        end
        PH_PROC: begin
          if (cmd_len(cmd_q[0]) == 4'h0) begin
            inv_q <= 1'b1;
            int_q <= 1'b1;
            nb_q <= 4'h0;
            ph_q <= PH_CMD;
          end else if (nb_q != cmd_len(cmd_q[0])) begin
            ph_q <= PH_CMD;
          end else begin
            nb_q <= 4'h0;
            ri_q <= 3'h0;
            ph_q <= PH_CMD;
            case (cmd_q[0][4:0])
              `OP_SPECIFY: dma_q <= ~cmd_q[2][`SPEC_NDMA_BIT];
              `OP_CONFIGURE: begin
                fifo_en_q <= ~cmd_q[`IX_CFG][`CFG_NOFIFO_BIT];
                thr_q <= cmd_q[`IX_CFG][3:0];
              end
              `OP_SENSE: begin
                inv_q <= 1'b0;
                int_q <= 1'b0;
                rn_q <= `RES_SENSE;
                ph_q <= PH_RES;
              end
              default: begin
                isrd_q <= (cmd_q[0][4:0] == `OP_READ);
                hreq_q <= (cmd_q[0][4:0] != `OP_READ);
                int_q <= ~dma_q & (cmd_q[0][4:0] != `OP_READ);
                end_q <= 1'b0;
                abn_q <= 1'b0;
                ddone_q <= 1'b0;
                secend_q <= 1'b0;
                sec_q <= cmd_q[`IX_R];
                bc_q <= 10'h000;
                hleft_q <= {nsec, 9'h000};
                rn_q <= `RES_RW;
                ph_q <= PH_EXEC;
              end
            endcase
          end
        end
        PH_EXEC: begin
          if (end_now) begin
            end_q <= 1'b1;
          end
          if (overrun | underrun) begin
            abn_q <= 1'b1;
          end
          if (overrun) begin
            ddone_q <= 1'b1;
          end
          if (isrd_q & empty) begin
            secend_q <= 1'b0;
          end
          if (step) begin
            if (bc_q == `SECTOR_LAST) begin
              bc_q <= 10'h000;
              secend_q <= isrd_q;
              if (end_now | (sec_q == cmd_q[`IX_EOT])) begin
                ddone_q <= 1'b1;
              end else begin
                sec_q <= sec_q + 8'h01;
              end
            end else begin
              bc_q <= bc_q + 10'h001;
            end
          end
          if (~dma_q) begin
            if (hreq_d & ~hreq_q) begin
              int_q <= 1'b1;
            end else if (~hreq_d) begin
              int_q <= 1'b0;
            end
            if (~isrd_q & tc_off) begin
              int_q <= 1'b0;
            end
          end
          if (ddone_q & empty) begin
            int_q <= 1'b1;
            ph_q <= PH_RES;
          end
        end
        PH_RES: begin
          if (hr_data) begin
            int_q <= 1'b0;
            ri_q <= ri_q + 3'h1;
            if (ri_q == rn_q - 3'h1) begin
              ri_q <= 3'h0;
              ph_q <= PH_CMD;
            end
          end
        end
        default: ph_q <= PH_CMD;
      endcase
    end
  end

  // Sector count of a transfer; an end sector below the start is taken as a single sector.
  always @* begin
    nsec = 9'h001;
    if (cmd_q[`IX_EOT] >= cmd_q[`IX_R]) begin
      nsec = {1'b0, cmd_q[`IX_EOT]} - {1'b0, cmd_q[`IX_R]} + 9'h001;
    end
  end
endmodule

/* testbench/flow_props.sv */
// Port-level concurrent checks for the floppy phase and FIFO flow block.
`timescale 1ns/10ps
module flow_props (
  input wire clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire [7:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire dma_acknowledge_n_in,
  input wire terminal_count_input_in,
  input wire dma_request_pin_out,
  input wire disk_wr_req_in,
  input wire disk_wr_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire acc = psel_in && penable_in;
  wire mapped = paddr_in[7:4] == 4'h0 && paddr_in[1:0] == 2'h0;
  // The count is only honoured while acknowledge qualifies it.
  sequence s_tc_acked;
    $rose(terminal_count_input_in) && !dma_acknowledge_n_in;
  endsequence
  chk_ready_high: assert property (pready_out) else $error("pready low");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr_out) else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && mapped |-> !pslverr_out) else $error("error on mapped access");
  chk_err_idle: assert property (!acc |-> !pslverr_out) else $error("error outside access");
  chk_err_single: assert property ($rose(pslverr_out) |=> $fell(pslverr_out)) else $error("error held");
  chk_rd_hold: assert property ($changed(prdata_out) |-> $past(psel_in && !penable_in)) else $error("read data moved");
  chk_wr_pulse: assert property (disk_wr_valid_out |-> $past(disk_wr_req_in)) else $error("stray write byte");
  chk_tc_drop: assert property (s_tc_acked |-> ##[1:8] !dma_request_pin_out) else $error("request kept");
endmodule
bind floppy_ctrl_phase_fifo_flow flow_props u_props (.clk_in, .rst_n_in, .psel_in, .penable_in, .paddr_in,
  .prdata_out, .pready_out, .pslverr_out, .dma_acknowledge_n_in, .terminal_count_input_in, .dma_request_pin_out,
  .disk_wr_req_in, .disk_wr_valid_out);

/* testbench/dma_host_model.sv */
// Behavioural system DMA controller that services read and write requests.
`timescale 1ns/10ps
module dma_host_model #(parameter int BYTES = 512) (
  input wire clk_in,
  input wire dma_request_pin_in,
  input wire write_mode_in,
  output logic dma_acknowledge_n_out,
  output logic dma_rd_n_out,
  output logic dma_wr_n_out,
  output logic [7:0] dma_data_out,
  output logic terminal_count_out,
  output int count_out
);
  initial begin
    dma_acknowledge_n_out = 1'b1;
    dma_rd_n_out = 1'b1;
    dma_wr_n_out = 1'b1;
    dma_data_out = 8'h00;
    terminal_count_out = 1'b0;
    count_out = 0;
  end
  // Write data goes out with the strobe and holds until the next write, so the sampled byte is stable.
  always begin
    @(posedge clk_in);
    if (dma_request_pin_in === 1'b1) begin
      dma_acknowledge_n_out <= 1'b0;
      @(posedge clk_in);
      if (write_mode_in) begin
        dma_wr_n_out <= 1'b0;
        dma_data_out <= count_out[7:0] ^ 8'h3C;
      end else begin
        dma_rd_n_out <= 1'b0;
      end
      terminal_count_out <= ((count_out % BYTES) == BYTES - 1);
      repeat (5) @(posedge clk_in);
      dma_rd_n_out <= 1'b1;
      dma_wr_n_out <= 1'b1;
      terminal_count_out <= 1'b0;
      repeat (5) @(posedge clk_in);
      dma_acknowledge_n_out <= 1'b1;
      count_out <= count_out + 1;
      repeat (2) @(posedge clk_in);
    end
  end
endmodule

/* testbench/tb.sv */
// Self-checking bench for the floppy phase and FIFO flow block.
`timescale 1ns/10ps
`include "floppy_flow_defs.vh"
module tb;
  logic clk_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, disk_rd_data_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rv;
  logic pready_out, pslverr_out, dma_acknowledge_n_in, dma_rd_n_in, dma_wr_n_in, terminal_count_input_in, err;
  logic [7:0] dma_data_in, dma_data_out, disk_wr_data_out;
  logic dma_request_pin_out, fdc_interrupt_pin_out, disk_wr_valid_out;
  logic disk_rd_valid_in = 1'b0, disk_wr_req_in = 1'b0, popping = 1'b0, dma_writes = 1'b0;
  int failures = 0, total_checks = 0, pulled = 0, moved, k;
  floppy_ctrl_phase_fifo_flow dut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .dma_acknowledge_n_in, .dma_rd_n_in, .dma_wr_n_in, .dma_data_in,
    .dma_data_out, .terminal_count_input_in, .dma_request_pin_out, .fdc_interrupt_pin_out, .disk_rd_valid_in,
    .disk_rd_data_in, .disk_wr_req_in, .disk_wr_data_out, .disk_wr_valid_out);
  dma_host_model host (.clk_in, .dma_request_pin_in(dma_request_pin_out), .dma_acknowledge_n_out(dma_acknowledge_n_in),
    .write_mode_in(dma_writes), .dma_rd_n_out(dma_rd_n_in), .dma_wr_n_out(dma_wr_n_in), .dma_data_out(dma_data_in),
    .terminal_count_out(terminal_count_input_in), .count_out(moved));
  initial forever #5 clk_in = ~clk_in;
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h000000, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rv = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wait_status(input logic [7:0] m, input logic [7:0] v);
    do apb(1'b0, `REG_STATUS, 8'h00); while ((rv[7:0] & m) !== v);
  endtask
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      wait_status(8'hC0, 8'h80);
      apb(1'b1, `REG_DATA, b[i]);
    end
  endtask
  task automatic results(input logic [7:0] e[$], input int from);
    foreach (e[i]) begin
      wait_status(8'hC0, 8'hC0);
      apb(1'b0, `REG_DATA, 8'h00);
      if (i >= from) check(rv[7:0], e[i]);
    end
    apb(1'b0, `REG_STATUS, 8'h00);
    check(rv[7:0], 8'h80);
  endtask
  task automatic wait_int();
    for (k = 0; k < 400 && fdc_interrupt_pin_out !== 1'b1; k++) @(posedge clk_in);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(negedge dma_rd_n_in) check(dma_data_out, moved[7:0] ^ 8'hA5);
  always @(posedge clk_in) begin
    if (disk_wr_valid_out === 1'b1) begin
      check(disk_wr_data_out, pulled[7:0] ^ 8'h3C);
      pulled++;
    end
  end
  // The disk side pulls one byte every twenty cycles, slower than either host path fills.
  initial begin
    repeat (2) begin
      wait (popping);
      for (int i = 0; i < 512; i++) begin
        repeat (19) @(posedge clk_in);
        disk_wr_req_in <= 1'b1;
        @(posedge clk_in);
        disk_wr_req_in <= 1'b0;
      end
      wait (!popping);
    end
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    apb(1'b0, `REG_STATUS, 8'h00);
    check(rv[7:0], 8'h80);
    apb(1'b0, `REG_LEVEL, 8'h00);
    check(rv[13:8], 6'h20);
    apb(1'b0, 8'h10, 8'h00);
    check(err, 1'b1);
    send('{8'h1F});
    wait_int();
    check(fdc_interrupt_pin_out, 1'b1);
    send('{`OP_SENSE});
    results('{8'h80, 8'h00}, 0);
    send('{`OP_CONFIGURE, 8'h00, 8'h03, 8'h00});
    apb(1'b0, `REG_LEVEL, 8'h00);
    check(rv[13:8], 6'h33);
    send('{`OP_READ, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h01, 8'h1B, 8'hFF});
    apb(1'b0, `REG_STATUS, 8'h00);
    check(rv[7], 1'b0);
    for (k = 0; k < 512; k++) begin
      if (k == 11) check(dma_request_pin_out, 1'b0);
      disk_rd_data_in <= k[7:0] ^ 8'hA5;
      disk_rd_valid_in <= 1'b1;
      @(posedge clk_in);
      disk_rd_valid_in <= 1'b0;
      repeat (k < 11 ? 1 : 23) @(posedge clk_in);
      if (k == 11) check(dma_request_pin_out, 1'b1);
    end
    wait_int();
    check(fdc_interrupt_pin_out, 1'b1);
    results('{8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02}, 0);
    check(moved, 512);
    send('{`OP_SPECIFY, 8'h00, 8'h01});
    send('{`OP_WRITE, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h01, 8'h1B, 8'hFF});
    wait_int();
    check(fdc_interrupt_pin_out, 1'b1);
    for (k = 0; k < 512; k++) begin
      if (k == 8) popping = 1'b1;
      wait_status(8'hE0, 8'hA0);
      apb(1'b1, `REG_DATA, k[7:0] ^ 8'h3C);
    end
    wait_status(8'hC0, 8'hC0);
    check(pulled, 512);
    results('{8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02}, 0);
    popping = 1'b0;
    dma_writes = 1'b1;
    send('{`OP_SPECIFY, 8'h00, 8'h00});
    send('{`OP_WRITE, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h01, 8'h1B, 8'hFF});
    apb(1'b0, `REG_STATUS, 8'h00);
    check(rv[7:4], 4'h1);
    check(dma_request_pin_out, 1'b1);
    popping = 1'b1;
    wait_status(8'hC0, 8'hC0);
    check(pulled, 1024);
    results('{8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02}, 0);
    check(moved, 1024);
    apb(1'b1, `REG_CTRL, 8'h01);
    apb(1'b0, `REG_LEVEL, 8'h00);
    check(rv[13:8], 6'h20);
    conclude();
  end
endmodule
